// ===== hdl/spi_pkg.sv
// shared constants and types for the serial port and its far peer
package spi_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam logic [7:0] ADDR_DATA   = 8'h08;
   localparam logic [7:0] ADDR_DIV    = 8'h0C;
   // control field positions
   localparam int         CTRL_PORT   = 0;
   localparam int         CTRL_MSTR   = 1;
   // status field positions
   localparam int         STAT_DONE   = 0;
   localparam int         STAT_WRITE_COLLISION_FLAG   = 1;
   localparam int         STAT_MODE_FAULT_FLAG   = 2;
   localparam int         STAT_BUSY   = 3;
   localparam int         STAT_SEL    = 4;
   // reset values
   localparam logic [1:0] CTRL_RESET  = 2'h0;
   localparam logic [7:0] DIV_RESET   = 8'h06;
   localparam logic [7:0] DATA_RESET  = 8'h00;
   // word length and far peer half period in pclk cycles
   localparam int         WORD_BITS   = 8;
   localparam logic [2:0] LAST_BIT    = 3'h7;
   localparam logic [7:0] FAR_HALF    = 8'h06;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW  = 2'b01,
      ST_HIGH = 2'b11,
      ST_DONE = 2'b10
   } xfer_e;

   // msb-first shift: next bit enters at the bottom
   function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic b);
      shift_in = {cur[6:0], b};
   endfunction : shift_in
endpackage : spi_pkg

// ===== hdl/spi_link_if.sv
// four-wire serial link joining the port and its far peer
`timescale 1ns/10ps
interface spi_link_if;
   logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe;
   logic far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe, far_miso_o, far_miso_oe;
   logic far_nss_o;
   logic sck, mosi, miso, nss;

   // idle levels stand in for the board pulls
   assign sck  = dev_sck_oe  ? dev_sck_o  : (far_sck_oe  ? far_sck_o  : 1'b0);
   assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b1);
   assign miso = dev_miso_oe ? dev_miso_o : (far_miso_oe ? far_miso_o : 1'b1);
   assign nss  = far_nss_o;

   modport device (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
                   output dev_miso_o, dev_miso_oe,
                   input  sck, mosi, miso, nss);
   modport far    (output far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe,
                   output far_miso_o, far_miso_oe, far_nss_o,
                   input  sck, mosi, miso);
endinterface : spi_link_if

// ===== hdl/spi_port.sv
// serial port, master or selected slave, with an apb register file
`timescale 1ns/10ps
module spi_port
   import spi_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial link
   spi_link_if.device       link
);
   logic [1:0]  ctrl_ff;
   logic [7:0]  div_ff, div_cnt_ff, lim;
   logic [7:0]  shift_ff, tx_buf_ff, rx_ff;
   logic [2:0]  cnt_ff;
   logic        bit_ff;
   logic        done_ff, write_collision_flag_ff, mode_fault_flag_ff;
   logic        sck_o_ff, mst_oe_ff, miso_oe_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff, pslverr_ff;
   logic [3:0]  s1_ff, s2_ff, s3_ff;
   xfer_e       state_ff;

   logic port_en, mstr_en, sck_s, mosi_s, miso_s, nss_s;
   logic sck_rise, sck_fall, nss_fall, nss_rise, selected, slave_mode;
   logic setup, access, wr_acc, data_wr, busy, tick, mode_fault_flag_evt, slave_end, master_end;

   // link inputs come from another clock domain: two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // idle levels of nss, miso, mosi, sck: no false edge right after reset
         s1_ff <= 4'hE;
         s2_ff <= 4'hE;
         s3_ff <= 4'hE;
      end else begin
         s1_ff <= {link.nss, link.miso, link.mosi, link.sck};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   assign port_en    = ctrl_ff[CTRL_PORT];
   assign mstr_en    = ctrl_ff[CTRL_MSTR];
   assign sck_s      = s2_ff[0];
   assign mosi_s     = s2_ff[1];
   assign miso_s     = s2_ff[2];
   assign nss_s      = s2_ff[3];
   assign sck_rise   = s2_ff[0] & ~s3_ff[0];
   assign sck_fall   = ~s2_ff[0] & s3_ff[0];
   assign nss_fall   = ~s2_ff[3] & s3_ff[3];
   assign nss_rise   = s2_ff[3] & ~s3_ff[3];
   assign slave_mode = port_en & ~mstr_en;
   assign selected   = slave_mode & ~nss_s;
   assign mode_fault_flag_evt   = port_en & mstr_en & ~nss_s;
   assign slave_end  = slave_mode & nss_rise;
   assign master_end = (state_ff == ST_DONE);
   assign busy       = (state_ff != ST_IDLE) | selected;

   // apb decode: setup cycle latches the answer, access lasts one cycle
   assign setup   = psel & ~penable;
   assign access  = psel & penable & pready_ff;
   assign wr_acc  = access & pwrite & ~pslverr_ff;
   assign data_wr = wr_acc & (paddr == ADDR_DATA);

   // half-period count, never below one pclk so sck spans two or more
   assign lim  = (div_ff == 8'h00) ? 8'h00 : div_ff - 8'h01;
   assign tick = (div_cnt_ff == lim);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         if (setup) begin
            case (paddr)
               ADDR_CTRL: prdata_ff <= {30'h0, ctrl_ff};
               ADDR_STAT: prdata_ff <= {27'h0, selected, busy, mode_fault_flag_ff, write_collision_flag_ff, done_ff};
               ADDR_DATA: prdata_ff <= {24'h0, rx_ff};
               ADDR_DIV:  prdata_ff <= {24'h0, div_ff};
               default:   pslverr_ff <= 1'b1;
            endcase
         end
      end
   end

   // hardware clear of the enables beats a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RESET;
         div_ff  <= DIV_RESET;
      end else begin
         if (mode_fault_flag_evt)
            ctrl_ff <= CTRL_RESET;
         else if (wr_acc && paddr == ADDR_CTRL)
            ctrl_ff <= pwdata[1:0];
         if (wr_acc && paddr == ADDR_DIV)
            div_ff <= pwdata[7:0];
      end
   end

   // sticky flags, write one to clear; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_ff <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         mode_fault_flag_ff <= 1'b0;
      end else begin
         done_ff <= (done_ff & ~(wr_acc && paddr == ADDR_STAT && pwdata[STAT_DONE]))
                    | master_end | slave_end;
         write_collision_flag_ff <= (write_collision_flag_ff & ~(wr_acc && paddr == ADDR_STAT && pwdata[STAT_WRITE_COLLISION_FLAG]))
                    | (data_wr & busy);
         mode_fault_flag_ff <= (mode_fault_flag_ff & ~(wr_acc && paddr == ADDR_STAT && pwdata[STAT_MODE_FAULT_FLAG]))
                    | mode_fault_flag_evt;
      end
   end

   // receive buffer and slave transmit buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_ff     <= DATA_RESET;
         tx_buf_ff <= DATA_RESET;
      end else begin
         if (master_end || slave_end)
            rx_ff <= shift_ff;
         if (data_wr && !busy && !mstr_en)
            tx_buf_ff <= pwdata[7:0];
      end
   end

   // shift engine: master sequencer plus slave edge follower
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff   <= ST_IDLE;
         shift_ff   <= DATA_RESET;
         cnt_ff     <= 3'h0;
         bit_ff     <= 1'b0;
         div_cnt_ff <= 8'h00;
         sck_o_ff   <= 1'b0;
      end else if (mode_fault_flag_evt) begin
         state_ff <= ST_IDLE;
         sck_o_ff <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (data_wr && port_en && mstr_en) begin
                  shift_ff   <= pwdata[7:0];
                  cnt_ff     <= 3'h0;
                  div_cnt_ff <= 8'h00;
                  state_ff   <= ST_LOW;
               end else if (slave_mode && nss_fall) begin
                  shift_ff <= tx_buf_ff;
                  cnt_ff   <= 3'h0;
               end else if (selected && sck_rise) begin
                  bit_ff <= mosi_s;
               end else if (selected && sck_fall) begin
                  shift_ff <= shift_in(shift_ff, bit_ff);
                  cnt_ff   <= cnt_ff + 3'h1;
               end
            end
            ST_LOW: begin
               if (tick) begin
                  div_cnt_ff <= 8'h00;
                  sck_o_ff   <= 1'b1;
                  bit_ff     <= miso_s;
                  state_ff   <= ST_HIGH;
               end else begin
                  div_cnt_ff <= div_cnt_ff + 8'h01;
               end
            end
            ST_HIGH: begin
               if (tick) begin
                  div_cnt_ff <= 8'h00;
                  sck_o_ff   <= 1'b0;
                  shift_ff   <= shift_in(shift_ff, bit_ff);
                  cnt_ff     <= cnt_ff + 3'h1;
                  state_ff   <= (cnt_ff == LAST_BIT) ? ST_DONE : ST_LOW;
               end else begin
                  div_cnt_ff <= div_cnt_ff + 8'h01;
               end
            end
            ST_DONE: state_ff <= ST_IDLE;
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // pin enables; an unselected slave lets go of miso
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mst_oe_ff  <= 1'b0;
         miso_oe_ff <= 1'b0;
      end else begin
         mst_oe_ff  <= port_en & mstr_en & ~mode_fault_flag_evt;
         miso_oe_ff <= selected;
      end
   end

   assign link.dev_sck_o   = sck_o_ff;
   assign link.dev_sck_oe  = mst_oe_ff;
   assign link.dev_mosi_o  = shift_ff[WORD_BITS-1];
   assign link.dev_mosi_oe = mst_oe_ff;
   assign link.dev_miso_o  = shift_ff[WORD_BITS-1];
   assign link.dev_miso_oe = miso_oe_ff;
   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
endmodule : spi_port

// ===== hdl/spi_far_peer.sv
// far peer on the link: an external master, or a slave selected by its user
`timescale 1ns/10ps
module spi_far_peer
   import spi_pkg::*;
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // user side
   input  wire logic       go,
   input  wire logic       sel,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte,
   output logic            done,
   output logic            busy,
   // serial link
   spi_link_if.far         link
);
   logic [2:0] s1_ff, s2_ff, s3_ff;
   logic [7:0] shift_ff, rx_ff, div_cnt_ff;
   logic [2:0] cnt_ff;
   logic       bit_ff, sck_ff, nss_ff, done_ff, busy_ff, sel_ff;
   xfer_e      state_ff;
   logic       sck_rise, sck_fall, tick, slave_on;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // idle levels of miso, mosi, sck
         s1_ff <= 3'h6;
         s2_ff <= 3'h6;
         s3_ff <= 3'h6;
      end else begin
         s1_ff <= {link.miso, link.mosi, link.sck};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   assign sck_rise = s2_ff[0] & ~s3_ff[0];
   assign sck_fall = ~s2_ff[0] & s3_ff[0];
   // half period of six pclk keeps the rate below a tenth of pclk
   assign tick     = (div_cnt_ff == FAR_HALF - 8'h01);
   assign slave_on = sel_ff & (state_ff == ST_IDLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff   <= ST_IDLE;
         shift_ff   <= DATA_RESET;
         rx_ff      <= DATA_RESET;
         cnt_ff     <= 3'h0;
         div_cnt_ff <= 8'h00;
         bit_ff     <= 1'b0;
         sck_ff     <= 1'b0;
         nss_ff     <= 1'b1;
         done_ff    <= 1'b0;
         busy_ff    <= 1'b0;
         sel_ff     <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         sel_ff  <= sel;
         case (state_ff)
            ST_IDLE: begin
               if (go && !sel) begin
                  shift_ff   <= tx_byte;
                  cnt_ff     <= 3'h0;
                  div_cnt_ff <= 8'h00;
                  nss_ff     <= 1'b0;
                  busy_ff    <= 1'b1;
                  state_ff   <= ST_LOW;
               end else if (sel && !sel_ff) begin
                  shift_ff <= tx_byte;
                  busy_ff  <= 1'b1;
               end else if (!sel && sel_ff) begin
                  rx_ff   <= shift_ff;
                  done_ff <= 1'b1;
                  busy_ff <= 1'b0;
               end else if (slave_on && sck_rise) begin
                  bit_ff <= s2_ff[1];
               end else if (slave_on && sck_fall) begin
                  shift_ff <= shift_in(shift_ff, bit_ff);
               end
            end
            ST_LOW: begin
               div_cnt_ff <= tick ? 8'h00 : div_cnt_ff + 8'h01;
               if (tick) begin
                  sck_ff   <= 1'b1;
                  bit_ff   <= s2_ff[2];
                  state_ff <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               div_cnt_ff <= tick ? 8'h00 : div_cnt_ff + 8'h01;
               if (tick) begin
                  sck_ff   <= 1'b0;
                  shift_ff <= shift_in(shift_ff, bit_ff);
                  cnt_ff   <= cnt_ff + 3'h1;
                  state_ff <= (cnt_ff == LAST_BIT) ? ST_DONE : ST_LOW;
               end
            end
            ST_DONE: begin
               nss_ff   <= 1'b1;
               rx_ff    <= shift_ff;
               done_ff  <= 1'b1;
               busy_ff  <= 1'b0;
               state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   assign link.far_sck_o   = sck_ff;
   assign link.far_sck_oe  = busy_ff & ~sel_ff;
   assign link.far_mosi_o  = shift_ff[WORD_BITS-1];
   assign link.far_mosi_oe = busy_ff & ~sel_ff;
   assign link.far_miso_o  = shift_ff[WORD_BITS-1];
   assign link.far_miso_oe = sel_ff;
   assign link.far_nss_o   = nss_ff;
   assign rx_byte          = rx_ff;
   assign done             = done_ff;
   assign busy             = busy_ff;
endmodule : spi_far_peer

// ===== testbench/spi_link_chk.sv
// concurrent checks on the four-wire link between the port and its far peer
`timescale 1ns/10ps
module spi_link_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // port end drivers
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe,
   input wire logic dev_mosi_o,
   input wire logic dev_mosi_oe,
   input wire logic dev_miso_oe,
   // far end drivers
   input wire logic far_sck_o,
   input wire logic far_mosi_o,
   input wire logic far_mosi_oe,
   input wire logic far_miso_oe,
   // resolved wires
   input wire logic sck,
   input wire logic nss
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_reset_quiet: assert property (
      $rose(presetn) |-> !dev_sck_oe && !dev_mosi_oe && !dev_miso_oe && nss)
      else $error("port drives the link right after reset");
   chk_miso_release: assert property (
      nss [*4] |-> !dev_miso_oe)
      else $error("miso still driven while not selected");
   chk_miso_single: assert property (
      !(dev_miso_oe && far_miso_oe))
      else $error("two ends drive miso");
   // reset divider is 6, so the port's clock stays high 6 cycles unless aborted
   chk_sck_half: assert property (
      $rose(dev_sck_o) |=> (dev_sck_o || !nss) [*5])
      else $error("port sck high phase too short");
   chk_far_sck_half: assert property (
      $rose(far_sck_o) |=> far_sck_o [*5])
      else $error("far sck high phase too short");
   chk_mosi_hold: assert property (
      dev_mosi_oe && sck && $past(sck) |-> $stable(dev_mosi_o))
      else $error("port mosi moved while sck high");
   chk_far_mosi_hold: assert property (
      far_mosi_oe && sck && $past(sck) |-> $stable(far_mosi_o))
      else $error("far mosi moved while sck high");
   chk_nss_frame: assert property (
      !dev_sck_oe && $rose(sck) |-> !nss)
      else $error("far master clocks with select high");
   chk_fault_drop: assert property (
      $fell(nss) && dev_sck_oe |-> ##[1:5] !dev_sck_oe)
      else $error("port keeps driving sck after mode fault");
endmodule : spi_link_chk

// ===== testbench/spi_master_slave_port_bench.sv
// self-checking bench: port and far peer facing each other on one link
`timescale 1ns/10ps
module spi_master_slave_port_bench;
   import spi_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        go, sel, done, busy, last_err;
   logic [7:0]  tx_byte, rx_byte;
   int          miscompares, n_checks;

   spi_link_if link ();
   spi_port spi_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.device));
   spi_far_peer spi_far_peer_inst (.pclk(pclk), .presetn(presetn), .go(go), .sel(sel),
      .tx_byte(tx_byte), .rx_byte(rx_byte), .done(done), .busy(busy), .link(link.far));
   spi_link_chk spi_link_chk_inst (.pclk(pclk), .presetn(presetn),
      .dev_sck_o(link.dev_sck_o), .dev_sck_oe(link.dev_sck_oe), .dev_mosi_o(link.dev_mosi_o),
      .dev_mosi_oe(link.dev_mosi_oe), .dev_miso_oe(link.dev_miso_oe),
      .far_sck_o(link.far_sck_o), .far_mosi_o(link.far_mosi_o),
      .far_mosi_oe(link.far_mosi_oe), .far_miso_oe(link.far_miso_oe),
      .sck(link.sck), .nss(link.nss));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task final_report;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic timeout(input string what);
      miscompares++;
      $display("mismatch at %0t: timeout waiting for %s", $time, what);
      final_report();
   endtask : timeout

   // one apb transfer; waits an edge first so psel is never reassigned in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) timeout("pready");
      rd       = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_stat(input int idx);
      int n;
      for (n = 0; n < 200; n++) begin
         apb(1'b0, ADDR_STAT, 32'h0);
         if (rd[idx] === 1'b1) return;
      end
      timeout("status flag");
   endtask : wait_stat

   task automatic wait_far_done;
      int n;
      for (n = 0; n < 400; n++) begin
         @(posedge pclk);
         if (done === 1'b1) return;
      end
      timeout("far done");
   endtask : wait_far_done

   task automatic t_reset;
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rd, 32'h0, "ctrl reset");
      apb(1'b0, ADDR_STAT, 32'h0);
      check(rd, 32'h0, "stat reset");
      apb(1'b0, ADDR_DIV, 32'h0);
      check(rd, {24'h0, DIV_RESET}, "div reset");
      apb(1'b1, ADDR_DIV, 32'h7);
      apb(1'b0, ADDR_DIV, 32'h0);
      check(rd, 32'h7, "div write");
      apb(1'b1, ADDR_DIV, {24'h0, DIV_RESET});
      check({31'h0, link.dev_miso_oe}, 32'h0, "miso released");
      apb(1'b0, 8'h10, 32'h0);
      check({31'h0, last_err}, 32'h1, "unmapped error");
      $display("test reset done");
   endtask : t_reset

   task automatic t_master;
      tx_byte <= 8'h5A;
      sel     <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h3);
      apb(1'b1, ADDR_DATA, 32'hA5);
      apb(1'b1, ADDR_DATA, 32'hFF);
      wait_stat(STAT_DONE);
      check({29'h0, rd[2:0]}, 32'h3, "done and collision");
      apb(1'b0, ADDR_DATA, 32'h0);
      check(rd, 32'h5A, "master rx");
      sel <= 1'b0;
      wait_far_done();
      check({24'h0, rx_byte}, 32'hA5, "far slave rx");
      apb(1'b1, ADDR_STAT, 32'h7);
      apb(1'b0, ADDR_STAT, 32'h0);
      check({29'h0, rd[2:0]}, 32'h0, "flags cleared");
      $display("test master done");
   endtask : t_master

   task automatic t_slave;
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b1, ADDR_DATA, 32'h3C);
      tx_byte <= 8'hC3;
      go      <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, ADDR_STAT, 32'h0);
      check(rd, 32'h18, "slave selected and busy");
      check({31'h0, busy}, 32'h1, "far master busy");
      wait_far_done();
      check({24'h0, rx_byte}, 32'h3C, "slave tx");
      wait_stat(STAT_DONE);
      apb(1'b0, ADDR_DATA, 32'h0);
      check(rd, 32'hC3, "slave rx");
      apb(1'b1, ADDR_STAT, 32'h7);
      apb(1'b0, ADDR_STAT, 32'h0);
      check(rd, 32'h0, "slave released");
      $display("test slave done");
   endtask : t_slave

   task automatic t_fault;
      apb(1'b1, ADDR_CTRL, 32'h3);
      tx_byte <= 8'h81;
      go      <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      wait_far_done();
      apb(1'b0, ADDR_STAT, 32'h0);
      check({31'h0, rd[STAT_MODE_FAULT_FLAG]}, 32'h1, "mode fault");
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rd, 32'h0, "enables cleared");
      $display("test fault done");
   endtask : t_fault

   initial begin
      miscompares = 0;
      n_checks    = 0;
      presetn     = 1'b0;
      {psel, penable, pwrite, go, sel} = 5'h00;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      tx_byte = 8'h00;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      t_reset();
      t_master();
      t_slave();
      t_fault();
      final_report();
   end
endmodule : spi_master_slave_port_bench
